// *** core/home_switch_homing_sequencer.sv ***
// Homing sequencer for methods 3 to 10 (home switch, positive limit, Z index)
`timescale 1ns/1ps
module home_switch_homing_sequencer #(
  parameter logic [homing_pkg::SPEED_W-1:0] FAST_DEFAULT = homing_pkg::FAST_SPEED_RST,
  parameter logic [homing_pkg::SPEED_W-1:0] SLOW_DEFAULT = homing_pkg::SLOW_SPEED_RST
) (
  input wire logic clk_i, // Control clock, 200 MHz
  input wire logic resetn_i, // Async reset, active low
  input wire logic drive_enabled_i, // Drive enabled; blocks method writes
  input wire logic cfg_we_i, // Configuration write strobe
  input wire logic [homing_pkg::METHOD_W-1:0] homing_method_select_i, // Method 0..99
  input wire logic [homing_pkg::SPEED_W-1:0] fast_search_speed_i, // First speed, rpm
  input wire logic [homing_pkg::SPEED_W-1:0] slow_search_speed_i, // Second speed, rpm
  input wire logic homing_trigger_i, // Trigger pin, rising edge starts
  input wire logic home_switch_i, // Home switch pin
  input wire logic pos_limit_i, // Positive limit switch pin
  input wire logic z_index_i, // Encoder Z index pin
  output logic motion_active_o, // Axis commanded to move
  output logic dir_forward_o, // 1 forward, 0 reverse
  output logic [homing_pkg::SPEED_W-1:0] speed_cmd_o, // Commanded speed, rpm
  output logic zero_latch_o, // One-cycle pulse at zero point
  output logic homing_done_o, // Homing complete, held till retrigger
  output logic method_ok_o, // Stored method is one this block runs
  output logic [homing_pkg::METHOD_W-1:0] method_o // Stored method
);
  import homing_pkg::*;

  logic trig_rise;
  logic home_lvl;
  logic home_rise;
  logic lim_lvl;
  logic z_rise;

  edge_sync u_trig (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(homing_trigger_i),
    .level_o(),
    .rise_o(trig_rise)
  );
  edge_sync u_home (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(home_switch_i),
    .level_o(home_lvl),
    .rise_o(home_rise)
  );
  edge_sync u_lim (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(pos_limit_i),
    .level_o(lim_lvl),
    .rise_o()
  );
  edge_sync u_z (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .pin_i(z_index_i),
    .level_o(),
    .rise_o(z_rise)
  );

  // Configuration registers
  logic [METHOD_W-1:0] method_reg;
  logic [SPEED_W-1:0] fast_reg;
  logic [SPEED_W-1:0] slow_reg;
  wire method_wr = cfg_we_i & ~drive_enabled_i & (homing_method_select_i <= METHOD_MAX);
  logic method_ok_reg;
  wire [METHOD_W-1:0] method_next = method_wr ? homing_method_select_i : method_reg;
  // Flag follows the value the method register takes at this edge
  wire method_next_ok = (method_next >= 7'd3) && (method_next <= 7'd10);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      method_reg <= METHOD_RST;
      fast_reg <= FAST_DEFAULT;
      slow_reg <= SLOW_DEFAULT;
      method_ok_reg <= 1'b0;
    end else begin
      method_ok_reg <= method_next_ok;
      if (method_wr) begin
        method_reg <= homing_method_select_i;
      end
      if (cfg_we_i) begin
        fast_reg <= fast_search_speed_i;
        slow_reg <= slow_search_speed_i;
      end
    end
  end

  wire supported = (method_reg >= 7'd3) && (method_reg <= 7'd10);
  wire limit_method = (method_reg >= 7'd7) && (method_reg <= 7'd10);

  // A homing run is a short program of up to four steps. Each step holds
  // a direction, a speed choice (1 = slow) and an end condition. Steps
  // ending on a Z condition latch the zero point; others advance.
  typedef struct packed {
    logic fwd;
    logic slow;
    step_end_t fin;
  } step_t;

  typedef step_t prog_t [4];

  // Reset step, a constant so the async reset branch loads no logic
  localparam step_t STEP_RST = '{fwd: 1'b0, slow: 1'b0, fin: END_HOME_HIGH};

  function automatic step_t mk(input logic fwd, input logic slow, input step_end_t fin);
    step_t s;
    s.fwd = fwd;
    s.slow = slow;
    s.fin = fin;
    return s;
  endfunction

  // Program chosen by method and home level at trigger
  function automatic prog_t pick(input logic [METHOD_W-1:0] m, input logic hi);
    prog_t p;
    p[0] = mk(1'b0, 1'b1, END_Z_ANY);
    p[1] = p[0];
    p[2] = p[0];
    p[3] = p[0];
    unique case (m)
      7'd3: begin
        if (!hi) begin
          p[0] = mk(1'b1, 1'b0, END_HOME_HIGH);
          p[1] = mk(1'b0, 1'b1, END_Z_LOW);
        end else begin
          p[0] = mk(1'b0, 1'b1, END_Z_LOW);
        end
      end
      7'd4: begin
        if (!hi) begin
          p[0] = mk(1'b1, 1'b0, END_HOME_HIGH);
          p[1] = mk(1'b0, 1'b1, END_Z_ANY);
        end else begin
          p[0] = mk(1'b0, 1'b1, END_HOME_LOW);
          p[1] = mk(1'b1, 1'b0, END_HOME_HIGH);
          p[2] = mk(1'b0, 1'b1, END_Z_ANY);
        end
      end
      7'd5: begin
        if (hi) begin
          p[0] = mk(1'b1, 1'b1, END_Z_LOW);
        end else begin
          p[0] = mk(1'b0, 1'b0, END_HOME_HIGH);
          p[1] = mk(1'b1, 1'b1, END_Z_LOW);
        end
      end
      7'd6: begin
        if (hi) begin
          p[0] = mk(1'b1, 1'b1, END_HOME_LOW);
          p[1] = mk(1'b0, 1'b0, END_HOME_HIGH);
          p[2] = mk(1'b1, 1'b1, END_Z_ANY);
        end else begin
          p[0] = mk(1'b0, 1'b0, END_HOME_HIGH);
          p[1] = mk(1'b1, 1'b1, END_Z_ANY);
        end
      end
      7'd7: begin
        if (hi) begin
          p[0] = mk(1'b0, 1'b1, END_Z_LOW);
        end else begin
          p[0] = mk(1'b1, 1'b0, END_HOME_HIGH);
          p[1] = mk(1'b0, 1'b1, END_Z_LOW);
        end
      end
      7'd8: begin
        if (!hi) begin
          p[0] = mk(1'b1, 1'b0, END_HOME_HIGH);
          p[1] = mk(1'b1, 1'b1, END_Z_ANY);
        end else begin
          p[0] = mk(1'b0, 1'b1, END_HOME_LOW);
          p[1] = mk(1'b1, 1'b1, END_Z_HIGH);
        end
      end
      7'd9: begin
        if (!hi) begin
          p[0] = mk(1'b1, 1'b0, END_HOME_HIGH);
          p[1] = mk(1'b1, 1'b1, END_HOME_LOW);
          p[2] = mk(1'b0, 1'b1, END_Z_HIGH);
        end else begin
          p[0] = mk(1'b1, 1'b1, END_HOME_LOW);
          p[1] = mk(1'b0, 1'b1, END_Z_HIGH);
        end
      end
      7'd10: begin
        if (!hi) begin
          p[0] = mk(1'b1, 1'b0, END_HOME_HIGH);
          p[1] = mk(1'b1, 1'b1, END_Z_LOW);
        end else begin
          p[0] = mk(1'b1, 1'b1, END_Z_LOW);
        end
      end
      default: begin
        p[0] = mk(1'b0, 1'b1, END_Z_ANY);
      end
    endcase
    return p;
  endfunction

  // Limit reversal program, entered from the first fast forward step
  function automatic prog_t pick_lim(input logic [METHOD_W-1:0] m);
    prog_t p;
    p[0] = mk(1'b0, 1'b0, END_HOME_HIGH);
    p[1] = mk(1'b0, 1'b1, END_Z_LOW);
    p[2] = p[1];
    p[3] = p[1];
    unique case (m)
      7'd8: begin
        p[1] = mk(1'b0, 1'b0, END_HOME_LOW);
        p[2] = mk(1'b1, 1'b1, END_Z_HIGH);
      end
      7'd9: begin
        p[1] = mk(1'b0, 1'b1, END_Z_ANY);
      end
      7'd10: begin
        p[1] = mk(1'b1, 1'b1, END_Z_LOW);
      end
      default: begin
        p[1] = mk(1'b0, 1'b1, END_Z_LOW);
      end
    endcase
    return p;
  endfunction

  seq_state_t state_reg;
  prog_t prog_reg;
  logic [1:0] idx_reg;
  logic lim_used_reg;
  logic zero_reg;
  logic done_reg;

  wire step_t cur = prog_reg[idx_reg];
  wire on_fast_fwd = cur.fwd & ~cur.slow & (idx_reg == 2'd0);

  // Limit only diverts the first fast forward step while home is low
  wire lim_hit = limit_method & ~lim_used_reg & on_fast_fwd & lim_lvl & ~home_lvl;

  logic step_end;
  always_comb begin
    step_end = 1'b0;
    unique case (cur.fin)
      END_HOME_HIGH: step_end = home_rise | home_lvl;
      END_HOME_LOW: step_end = ~home_lvl;
      END_Z_ANY: step_end = z_rise;
      END_Z_LOW: step_end = z_rise & ~home_lvl;
      END_Z_HIGH: step_end = z_rise & home_lvl;
      default: step_end = 1'b0;
    endcase
  end

  wire is_z_step = (cur.fin == END_Z_ANY) || (cur.fin == END_Z_LOW) || (cur.fin == END_Z_HIGH);
  wire start = trig_rise & supported;

  prog_t start_prog;
  prog_t lim_prog;
  always_comb begin
    start_prog = pick(method_reg, home_lvl);
    lim_prog = pick_lim(method_reg);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= ST_IDLE;
      prog_reg <= '{STEP_RST, STEP_RST, STEP_RST, STEP_RST};
      idx_reg <= 2'd0;
      lim_used_reg <= 1'b0;
      zero_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
      if (start) begin
        // Retrigger restarts from any state and clears completion
        prog_reg <= start_prog;
        idx_reg <= 2'd0;
        lim_used_reg <= 1'b0;
        done_reg <= 1'b0;
        state_reg <= ST_RUN;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            state_reg <= ST_IDLE;
          end
          ST_RUN: begin
            if (lim_hit) begin
              prog_reg <= lim_prog;
              idx_reg <= 2'd0;
              lim_used_reg <= 1'b1;
            end else if (step_end && is_z_step) begin
              zero_reg <= 1'b1;
              done_reg <= 1'b1;
              state_reg <= ST_DONE;
            end else if (step_end) begin
              idx_reg <= idx_reg + 2'd1;
            end
          end
          ST_DONE: begin
            state_reg <= ST_DONE;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Step in force after this edge, so direction and speed do not lag a
  // step change by a cycle
  wire in_run = (state_reg == ST_RUN);
  wire [1:0] step_inc = idx_reg + 2'd1;
  step_t nxt;
  always_comb begin
    nxt = cur;
    if (start) begin
      nxt = start_prog[0];
    end else if (in_run && lim_hit) begin
      nxt = lim_prog[0];
    end else if (in_run && step_end && !is_z_step) begin
      nxt = prog_reg[step_inc];
    end
  end

  // Output flops; speed follows live settings so edits act at once
  logic active_reg;
  logic fwd_reg;
  logic [SPEED_W-1:0] speed_reg;
  wire run_next = (state_reg == ST_RUN) & ~(step_end & is_z_step) | start;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_reg <= 1'b0;
      fwd_reg <= 1'b0;
      speed_reg <= '0;
    end else begin
      active_reg <= run_next;
      fwd_reg <= nxt.fwd;
      speed_reg <= run_next ? (nxt.slow ? slow_reg : fast_reg) : '0;
    end
  end

  assign motion_active_o = active_reg;
  assign dir_forward_o = fwd_reg;
  assign speed_cmd_o = speed_reg;
  assign zero_latch_o = zero_reg;
  assign homing_done_o = done_reg;
  assign method_o = method_reg;
  assign method_ok_o = method_ok_reg;
endmodule

// *** shared/homing_pkg.sv ***
// Constants and types for the home-switch homing sequencer
package homing_pkg;
  localparam int SPEED_W = 15;
  localparam int METHOD_W = 7;
  localparam logic [SPEED_W-1:0] FAST_SPEED_RST = 15'h01F4;
  localparam logic [SPEED_W-1:0] SLOW_SPEED_RST = 15'h0064;
  localparam logic [METHOD_W-1:0] METHOD_RST = 7'h00;
  localparam logic [METHOD_W-1:0] METHOD_MAX = 7'h63;

  // Motion step end condition: what ends the step
  typedef enum logic [2:0] {
    END_HOME_HIGH = 3'h0,
    END_HOME_LOW = 3'h1,
    END_Z_ANY = 3'h2,
    END_Z_LOW = 3'h3,
    END_Z_HIGH = 3'h4
  } step_end_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } seq_state_t;
endpackage

// *** core/edge_sync.sv ***
// Two-stage synchroniser for one pin input, with rise detect
`timescale 1ns/1ps
module edge_sync (
  input wire logic clk_i, // Control clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic pin_i, // Asynchronous pin
  output logic level_o, // Synchronised level
  output logic rise_o // One-cycle pulse on rising edge
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~last_reg;
endmodule

// *** verification/homing_properties.sv ***
// Port-level assertions for the homing sequencer
`timescale 1ns/1ps
module homing_properties (
  input wire logic clk_i, // Control clock
  input wire logic resetn_i, // Async reset, active low
  input wire logic drive_enabled_i, // Drive enabled
  input wire logic cfg_we_i, // Configuration write strobe
  input wire logic [homing_pkg::METHOD_W-1:0] homing_method_select_i, // Method written
  input wire logic homing_trigger_i, // Trigger pin
  input wire logic motion_active_o, // Axis commanded to move
  input wire logic [homing_pkg::SPEED_W-1:0] speed_cmd_o, // Commanded speed
  input wire logic zero_latch_o, // Zero point pulse
  input wire logic homing_done_o, // Homing complete
  input wire logic method_ok_o, // Stored method supported
  input wire logic [homing_pkg::METHOD_W-1:0] method_o // Stored method
);
  import homing_pkg::*;
  // Counts trigger-low cycles; done may only drop after a fresh trigger
  logic [3:0] low_cnt_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      low_cnt_reg <= 4'h0;
    end else if (homing_trigger_i) begin
      low_cnt_reg <= 4'h0;
    end else if (low_cnt_reg != 4'hF) begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  speed_idle_a:
    assert property (!motion_active_o |-> speed_cmd_o == '0) else $error("speed while idle");
  zero_stop_a:
    assert property (zero_latch_o |-> homing_done_o && !motion_active_o)
      else $error("zero latch without stop");
  done_cause_a:
    assert property ($rose(homing_done_o) |-> zero_latch_o) else $error("done without latch");
  done_hold_a:
    assert property (low_cnt_reg == 4'hF && homing_done_o |=> homing_done_o)
      else $error("done dropped");
  method_ok_a:
    assert property (method_ok_o == (method_o >= 7'h03 && method_o <= 7'h0A))
      else $error("method ok wrong");
  method_lock_a:
    assert property (cfg_we_i && (drive_enabled_i || homing_method_select_i > METHOD_MAX)
      |=> $stable(method_o)) else $error("method write not refused");
  method_load_a:
    assert property (cfg_we_i && !drive_enabled_i && homing_method_select_i <= METHOD_MAX
      |=> method_o == $past(homing_method_select_i)) else $error("method not loaded");
  start_ok_a:
    assert property ($rose(motion_active_o) |-> method_ok_o) else $error("bad method ran");
  zero_pulse_a:
    assert property (zero_latch_o |=> !zero_latch_o) else $error("zero latch too long");
  done_still_a:
    assert property (homing_done_o |-> !motion_active_o) else $error("motion after done");
endmodule
bind home_switch_homing_sequencer homing_properties i_homing_properties (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .drive_enabled_i(drive_enabled_i),
  .cfg_we_i(cfg_we_i),
  .homing_method_select_i(homing_method_select_i),
  .homing_trigger_i(homing_trigger_i),
  .motion_active_o(motion_active_o),
  .speed_cmd_o(speed_cmd_o),
  .zero_latch_o(zero_latch_o),
  .homing_done_o(homing_done_o),
  .method_ok_o(method_ok_o),
  .method_o(method_o)
);

// *** verification/axis_model.sv ***
// Axis model: position drives home switch, positive limit and Z index
`timescale 1ns/1ps
module axis_model #(
  parameter int HOME_LO = 100,
  parameter int HOME_HI = 199,
  parameter int LIMIT_AT = 300,
  parameter int Z_PITCH = 32
) (
  input wire logic clk_i, // Control clock
  input wire logic load_i, // Place axis at load_pos_i
  input wire logic [31:0] load_pos_i, // Start position
  input wire logic motion_active_i, // Move one count a cycle
  input wire logic dir_forward_i, // Direction
  output logic home_switch_o, // High inside home window
  output logic pos_limit_o, // High at and past limit
  output logic z_index_o, // High at one count a pitch
  output int z_pos_o // Position of last Z
);
  int pos;
  always_ff @(posedge clk_i) begin
    if (load_i) begin
      pos <= load_pos_i;
    end else if (motion_active_i) begin
      pos <= dir_forward_i ? pos + 1 : pos - 1;
    end
    if (z_index_o) begin
      z_pos_o <= pos;
    end
  end
  // Speed not modelled: one count a cycle keeps Z clear of switch overshoot
  assign home_switch_o = pos >= HOME_LO && pos <= HOME_HI;
  assign pos_limit_o = pos >= LIMIT_AT;
  assign z_index_o = pos % Z_PITCH == Z_PITCH / 2;
endmodule

// *** verification/testbench.sv ***
// Self-checking bench: homing runs against a simulated axis
`timescale 1ns/1ps
module testbench;
  import homing_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic drive_enabled_i = 1'b0;
  logic cfg_we_i = 1'b0;
  logic [METHOD_W-1:0] homing_method_select_i = 7'h00;
  logic [SPEED_W-1:0] fast_search_speed_i = 15'h7FFF;
  logic [SPEED_W-1:0] slow_search_speed_i = 15'h0001;
  logic homing_trigger_i = 1'b0;
  logic home_switch_i;
  logic pos_limit_i;
  logic z_index_i;
  logic motion_active_o;
  logic dir_forward_o;
  logic [SPEED_W-1:0] speed_cmd_o;
  logic zero_latch_o;
  logic homing_done_o;
  logic method_ok_o;
  logic [METHOD_W-1:0] method_o;
  logic load = 1'b1;
  int load_pos = 0;
  int z_pos;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  home_switch_homing_sequencer i_home_switch_homing_sequencer (.clk_i, .resetn_i,
    .drive_enabled_i, .cfg_we_i, .homing_method_select_i, .fast_search_speed_i,
    .slow_search_speed_i, .homing_trigger_i, .home_switch_i, .pos_limit_i, .z_index_i,
    .motion_active_o, .dir_forward_o, .speed_cmd_o, .zero_latch_o, .homing_done_o,
    .method_ok_o, .method_o);
  axis_model i_axis_model (.clk_i, .load_i(load), .load_pos_i(load_pos),
    .motion_active_i(motion_active_o), .dir_forward_i(dir_forward_o),
    .home_switch_o(home_switch_i), .pos_limit_o(pos_limit_i), .z_index_o(z_index_i),
    .z_pos_o(z_pos));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic write_cfg(input logic [METHOD_W-1:0] m, input logic en);
    drive_enabled_i = en;
    homing_method_select_i = m;
    cfg_we_i = 1'b1;
    tick();
    cfg_we_i = 1'b0;
    tick();
  endtask
  // Axis held at p through the write so pins settle before the trigger
  task automatic run_home(input logic [METHOD_W-1:0] m, input int p, input logic fwd,
      input logic fast, input int zp);
    int n;
    load_pos = p;
    write_cfg(m, 1'b0);
    load = 1'b0;
    homing_trigger_i = 1'b1;
    n = 0;
    while (motion_active_o !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    check("started", 1'b1, motion_active_o);
    check("first_dir", fwd, dir_forward_o);
    check("first_speed", fast ? fast_search_speed_i : slow_search_speed_i, speed_cmd_o);
    check("done_cleared", 1'b0, homing_done_o);
    homing_trigger_i = 1'b0;
    while (zero_latch_o !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    check("zero_seen", 1'b1, zero_latch_o);
    check("zero_point", zp, z_pos);
    check("stopped", 17'h0_8000, {motion_active_o, homing_done_o, speed_cmd_o});
    repeat (4) tick();
    check("done_held", 1'b1, homing_done_o);
    load = 1'b1;
  endtask
  task automatic reset_state();
    check("reset_out", 32'h0000_0000, {motion_active_o, homing_done_o, method_ok_o,
      speed_cmd_o, zero_latch_o, method_o});
  endtask
  task automatic cfg_rules();
    write_cfg(7'h05, 1'b1);
    check("method_locked", 7'h00, method_o);
    write_cfg(7'h64, 1'b0);
    check("method_range", 7'h00, method_o);
    write_cfg(7'h63, 1'b0);
    check("method_max", 7'h63, method_o);
    for (int m = 2; m < 12; m++) begin
      write_cfg(7'(m), 1'b0);
      check("method_ok", m >= 3 && m <= 10, method_ok_o);
    end
    homing_trigger_i = 1'b1;
    repeat (8) tick();
    check("no_start", 1'b0, motion_active_o);
    homing_trigger_i = 1'b0;
    repeat (4) tick();
  endtask
  task automatic scen_home_only();
    run_home(7'h03, 0, 1'b1, 1'b1, 80);
    run_home(7'h03, 150, 1'b0, 1'b0, 80);
    run_home(7'h04, 0, 1'b1, 1'b1, 80);
    run_home(7'h04, 150, 1'b0, 1'b0, 80);
    run_home(7'h05, 150, 1'b1, 1'b0, 208);
    run_home(7'h05, 220, 1'b0, 1'b1, 208);
    run_home(7'h06, 150, 1'b1, 1'b0, 208);
    run_home(7'h06, 220, 1'b0, 1'b1, 208);
  endtask
  task automatic scen_with_limit();
    run_home(7'h07, 150, 1'b0, 1'b0, 80);
    run_home(7'h07, 0, 1'b1, 1'b1, 80);
    run_home(7'h07, 250, 1'b1, 1'b1, 80);
    run_home(7'h08, 0, 1'b1, 1'b1, 112);
    run_home(7'h08, 150, 1'b0, 1'b0, 112);
    run_home(7'h08, 250, 1'b1, 1'b1, 112);
    run_home(7'h09, 0, 1'b1, 1'b1, 176);
    run_home(7'h09, 150, 1'b1, 1'b0, 176);
    run_home(7'h09, 250, 1'b1, 1'b1, 176);
    run_home(7'h0A, 0, 1'b1, 1'b1, 208);
    run_home(7'h0A, 150, 1'b1, 1'b0, 208);
    run_home(7'h0A, 250, 1'b1, 1'b1, 208);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    reset_state();
    cfg_rules();
    scen_home_only();
    scen_with_limit();
    complete_run();
  end
endmodule
